// file: rtl/sdd_pkg.sv
// Constants, types and the lookup function for the packed-SIMD sub-class decoder.
`default_nettype none
package sdd_pkg;
  // Instruction field positions.
  localparam int MAJOR_HI = 31;
  localparam int MAJOR_LO = 26;
  localparam int SRCA_HI = 25;
  localparam int SRCA_LO = 21;
  localparam int SRCB_HI = 20;
  localparam int SRCB_LO = 16;
  localparam int DST_HI = 15;
  localparam int DST_LO = 11;
  localparam int ACC_HI = 12;
  localparam int ACC_LO = 11;
  localparam int ACC_PAD_HI = 15;
  localparam int ACC_PAD_LO = 13;
  localparam int OP_HI = 10;
  localparam int OP_LO = 6;
  localparam int FUNC_HI = 5;
  localparam int FUNC_LO = 0;
  localparam int RDMASK_HI = 21;
  localparam int RDMASK_LO = 16;
  localparam int WRMASK_HI = 16;
  localparam int WRMASK_LO = 11;

  // Major opcode and function codes of the covered sub-classes.
  localparam logic [5:0] EXTENDED_MAJOR_OPCODE = 6'h1F;
  localparam logic [5:0] FUNC_INDEXED_LOAD = 6'h0A;
  localparam logic [5:0] FUNC_SHIFT_32 = 6'h13;
  localparam logic [5:0] FUNC_SHIFT_64 = 6'h17;
  localparam logic [5:0] FUNC_DOT_32 = 6'h30;
  localparam logic [5:0] FUNC_EXTRACT_32 = 6'h38;

  // Assigned op codes of each sub-class, one bit per op value (bit = {row, column}).
  localparam logic [31:0] MAP_INDEXED_LOAD = 32'h0000_0151;
  localparam logic [31:0] MAP_SHIFT_32 = 32'h0AF0_FFFF;
  localparam logic [31:0] MAP_SHIFT_64 = 32'h0AFF_FFFF;
  localparam logic [31:0] MAP_DOT_32 = 32'h0F55_BBFF;
  localparam logic [31:0] MAP_DOT_64 = 32'hFFFF_FFFF;
  localparam logic [31:0] MAP_EXTRACT_32 = 32'h8C0C_CCFF;

  // Individual op codes.
  localparam logic [4:0] OP_INDEXED_WORD_LOAD = 5'h00;
  localparam logic [4:0] OP_INDEXED_HALF_LOAD = 5'h04;
  localparam logic [4:0] OP_INDEXED_UNSIGNED_BYTE_LOAD = 5'h06;
  localparam logic [4:0] OP_INDEXED_DOUBLE_LOAD = 5'h08;
  localparam logic [4:0] OP_DOUBLE_MULTIPLY_ADD = 5'h02;
  localparam logic [4:0] OP_DOUBLE_MULTIPLY_SUBTRACT = 5'h0A;
  localparam logic [4:0] OP_DOUBLE_UNSIGNED_MULTIPLY_ADD = 5'h1D;
  localparam logic [4:0] OP_DOUBLE_UNSIGNED_MULTIPLY_SUBTRACT = 5'h1F;
  localparam logic [4:0] OP_ROUNDING_EXTRACT = 5'h04;
  localparam logic [4:0] OP_ROUNDING_EXTRACT_VARIABLE = 5'h05;
  localparam logic [4:0] OP_CONTROL_REGISTER_READ = 5'h12;
  localparam logic [4:0] OP_CONTROL_REGISTER_WRITE = 5'h13;
  localparam logic [4:0] OP_ACCUMULATOR_PAIR_SHIFT = 5'h1A;
  localparam logic [4:0] OP_ACCUMULATOR_PAIR_SHIFT_VARIABLE = 5'h1B;
  localparam logic [4:0] OP_ACCUMULATOR_SHIFT_IN = 5'h1F;

  // Sub-class selected by the function field.
  typedef enum logic [6:0] {
    SDD_CLS_NONE = 7'b000_0001,
    SDD_CLS_INDEXED_LOAD = 7'b000_0010,
    SDD_CLS_SHIFT_32 = 7'b000_0100,
    SDD_CLS_SHIFT_64 = 7'b000_1000,
    SDD_CLS_DOT_32 = 7'b001_0000,
    SDD_CLS_DOT_64 = 7'b010_0000,
    SDD_CLS_EXTRACT_32 = 7'b100_0000
  } sdd_class_t;

  // Element width of the operation.
  typedef enum logic [1:0] {
    SDD_ELEM_BYTE = 2'h0,
    SDD_ELEM_HALF = 2'h1,
    SDD_ELEM_WORD = 2'h2,
    SDD_ELEM_DOUBLE = 2'h3
  } sdd_elem_t;

  // Shift direction for the packed shift classes.
  typedef enum logic [1:0] {
    SDD_SHIFT_NONE = 2'h0,
    SDD_SHIFT_LEFT = 2'h1,
    SDD_SHIFT_LOGIC_RIGHT = 2'h2,
    SDD_SHIFT_ARITH_RIGHT = 2'h3
  } sdd_shift_t;

  // Maps a function code to its sub-class.
  function automatic sdd_class_t class_of(input logic [5:0] func);
    sdd_class_t c;
    c = SDD_CLS_NONE;
    if (func == FUNC_INDEXED_LOAD) c = SDD_CLS_INDEXED_LOAD;
    else if (func == FUNC_SHIFT_32) c = SDD_CLS_SHIFT_32;
    else if (func == FUNC_SHIFT_64) c = SDD_CLS_SHIFT_64;
    else if (func == FUNC_DOT_32) c = SDD_CLS_DOT_32;
    else if (func == FUNC_EXTRACT_32) c = SDD_CLS_EXTRACT_32;
    return c;
  endfunction
endpackage
`default_nettype wire

// file: rtl/sdd_fields_if.sv
// Interface carrying the split instruction fields between decoder modules.
`timescale 1ns/1ps
`default_nettype none
interface sdd_fields_if;
  logic is_major;
  logic [4:0] src_a;
  logic [4:0] src_b;
  logic [4:0] dst;
  logic [4:0] op;
  logic [5:0] func;
  logic [1:0] acc;
  logic acc_pad_zero;
  logic [5:0] rd_mask;
  logic [5:0] wr_mask;
  modport producer (output is_major, src_a, src_b, dst, op, func, acc, acc_pad_zero,
    rd_mask, wr_mask);
  modport consumer (input is_major, src_a, src_b, dst, op, func, acc, acc_pad_zero,
    rd_mask, wr_mask);
endinterface
`default_nettype wire

// file: rtl/sdd_field_split.sv
// Splits a 32-bit instruction word into its named fields.
`timescale 1ns/1ps
`default_nettype none
module sdd_field_split (
  // Instruction word.
  input wire logic [31:0] instr,
  // Split fields.
  sdd_fields_if.producer fld
);
  assign fld.is_major = instr[sdd_pkg::MAJOR_HI:sdd_pkg::MAJOR_LO] ==
    sdd_pkg::EXTENDED_MAJOR_OPCODE;
  assign fld.src_a = instr[sdd_pkg::SRCA_HI:sdd_pkg::SRCA_LO];
  assign fld.src_b = instr[sdd_pkg::SRCB_HI:sdd_pkg::SRCB_LO];
  assign fld.dst = instr[sdd_pkg::DST_HI:sdd_pkg::DST_LO];
  assign fld.op = instr[sdd_pkg::OP_HI:sdd_pkg::OP_LO];
  assign fld.func = instr[sdd_pkg::FUNC_HI:sdd_pkg::FUNC_LO];
  assign fld.acc = instr[sdd_pkg::ACC_HI:sdd_pkg::ACC_LO];
  assign fld.acc_pad_zero = instr[sdd_pkg::ACC_PAD_HI:sdd_pkg::ACC_PAD_LO] == 3'h0;
  assign fld.rd_mask = instr[sdd_pkg::RDMASK_HI:sdd_pkg::RDMASK_LO];
  assign fld.wr_mask = instr[sdd_pkg::WRMASK_HI:sdd_pkg::WRMASK_LO];
endmodule // sdd_field_split
`default_nettype wire

// file: rtl/sdd_op_table.sv
// Looks up whether an op code is assigned within a sub-class.
`timescale 1ns/1ps
`default_nettype none
module sdd_op_table (
  // Lookup request.
  input wire sdd_pkg::sdd_class_t cls,
  input wire logic [4:0] op,
  // Lookup answer.
  output logic assigned
);
  logic [31:0] map;

  always_comb begin
    case (cls)
      sdd_pkg::SDD_CLS_INDEXED_LOAD: map = sdd_pkg::MAP_INDEXED_LOAD;
      sdd_pkg::SDD_CLS_SHIFT_32: map = sdd_pkg::MAP_SHIFT_32;
      sdd_pkg::SDD_CLS_SHIFT_64: map = sdd_pkg::MAP_SHIFT_64;
      sdd_pkg::SDD_CLS_DOT_32: map = sdd_pkg::MAP_DOT_32;
      sdd_pkg::SDD_CLS_DOT_64: map = sdd_pkg::MAP_DOT_64;
      sdd_pkg::SDD_CLS_EXTRACT_32: map = sdd_pkg::MAP_EXTRACT_32;
      default: map = 32'h0000_0000;
    endcase
    assigned = map[op];
  end
endmodule // sdd_op_table
`default_nettype wire

// file: rtl/sdd_decoder.sv
// Decoder for the packed shift, indexed load, dot-product and extract sub-classes.
`timescale 1ns/1ps
`default_nettype none
module sdd_decoder #(
  parameter bit DOT_64_ENABLE = 1'b1
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Instruction from fetch.
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic hold,
  // Same-cycle decode result.
  output logic dec_hit,
  output logic dec_reserved,
  output sdd_pkg::sdd_class_t dec_class,
  output logic [4:0] dec_op,
  output sdd_pkg::sdd_elem_t dec_elem,
  output sdd_pkg::sdd_shift_t dec_shift,
  output logic dec_variable,
  output logic dec_round,
  output logic dec_saturate,
  output logic dec_double_mul,
  output logic dec_load,
  output logic dec_load_unsigned,
  output logic dec_ctrl_read,
  output logic dec_ctrl_write,
  output logic dec_acc_shift_in,
  output logic dec_acc_pair_shift,
  // Register and accumulator specifiers.
  output logic [4:0] dec_src_a,
  output logic dec_src_a_used,
  output logic [4:0] dec_src_b,
  output logic dec_src_b_used,
  output logic [4:0] dec_dst,
  output logic dec_dst_used,
  output logic [1:0] dec_acc,
  output logic dec_acc_read,
  output logic dec_acc_write,
  // Immediates.
  output logic [4:0] dec_imm5,
  output logic [5:0] dec_mask,
  // Execute-stage copy.
  output logic ex_valid_ff,
  output logic ex_reserved_ff,
  output sdd_pkg::sdd_class_t ex_class_ff,
  output logic [4:0] ex_op_ff,
  output logic [1:0] ex_acc_ff,
  output logic [4:0] ex_dst_ff
);
  sdd_fields_if fld ();
  sdd_pkg::sdd_class_t cls;
  logic op_assigned;
  logic [1:0] row;
  logic [2:0] col;

  sdd_field_split u_split (
    .instr(instr),
    .fld(fld)
  );

  // The 64-bit dot class shares the 32-bit function code on this map.
  always_comb begin
    cls = sdd_pkg::class_of(fld.func);
    if (!fld.is_major || !instr_valid) begin
      cls = sdd_pkg::SDD_CLS_NONE;
    end else if (cls == sdd_pkg::SDD_CLS_DOT_32 && DOT_64_ENABLE &&
                 fld.op == sdd_pkg::OP_DOUBLE_MULTIPLY_ADD) begin
      cls = sdd_pkg::SDD_CLS_DOT_64;
    end
  end

  sdd_op_table u_table (
    .cls(cls),
    .op(fld.op),
    .assigned(op_assigned)
  );

  assign row = fld.op[4:3];
  assign col = fld.op[2:0];

  // Class, hit and reserved flags.
  always_comb begin
    dec_class = cls;
    dec_op = fld.op;
    dec_hit = cls != sdd_pkg::SDD_CLS_NONE;
    dec_reserved = dec_hit && !op_assigned;
    if ((cls == sdd_pkg::SDD_CLS_DOT_32 || cls == sdd_pkg::SDD_CLS_DOT_64) &&
        !fld.acc_pad_zero) begin
      dec_reserved = 1'b1;
    end
    if (cls == sdd_pkg::SDD_CLS_EXTRACT_32 && fld.op != sdd_pkg::OP_CONTROL_REGISTER_READ &&
        fld.op != sdd_pkg::OP_CONTROL_REGISTER_WRITE && !fld.acc_pad_zero) begin
      dec_reserved = 1'b1;
    end
  end

  // Element, shift, variable, round and saturate attributes of each sub-class.
  always_comb begin
    dec_shift = sdd_pkg::SDD_SHIFT_NONE;
    dec_variable = 1'b0;
    dec_round = 1'b0;
    dec_saturate = 1'b0;
    dec_elem = sdd_pkg::SDD_ELEM_WORD;
    if (cls == sdd_pkg::SDD_CLS_SHIFT_32 || cls == sdd_pkg::SDD_CLS_SHIFT_64) begin
      dec_variable = col[1];
      case (row)
        2'h0: begin
          dec_elem = sdd_pkg::SDD_ELEM_BYTE;
          if (col[2]) begin
            dec_shift = sdd_pkg::SDD_SHIFT_ARITH_RIGHT;
            dec_round = col[0];
          end else if (col[0]) begin
            dec_shift = sdd_pkg::SDD_SHIFT_LOGIC_RIGHT;
          end else begin
            dec_shift = sdd_pkg::SDD_SHIFT_LEFT;
          end
        end
        2'h1, 2'h2: begin
          dec_elem = row == 2'h1 ? sdd_pkg::SDD_ELEM_HALF : sdd_pkg::SDD_ELEM_WORD;
          if (col[0]) begin
            dec_shift = sdd_pkg::SDD_SHIFT_ARITH_RIGHT;
            dec_round = col[2];
          end else begin
            dec_shift = sdd_pkg::SDD_SHIFT_LEFT;
            dec_saturate = col[2];
          end
        end
        default: begin
          dec_elem = sdd_pkg::SDD_ELEM_HALF;
          dec_shift = sdd_pkg::SDD_SHIFT_LOGIC_RIGHT;
        end
      endcase
    end else if (cls == sdd_pkg::SDD_CLS_INDEXED_LOAD) begin
      case (fld.op)
        sdd_pkg::OP_INDEXED_HALF_LOAD: dec_elem = sdd_pkg::SDD_ELEM_HALF;
        sdd_pkg::OP_INDEXED_UNSIGNED_BYTE_LOAD: dec_elem = sdd_pkg::SDD_ELEM_BYTE;
        sdd_pkg::OP_INDEXED_DOUBLE_LOAD: dec_elem = sdd_pkg::SDD_ELEM_DOUBLE;
        default: dec_elem = sdd_pkg::SDD_ELEM_WORD;
      endcase
    end else if (cls == sdd_pkg::SDD_CLS_DOT_32) begin
      // Row 00 cols 4..6, row 01 cols 4..5, row 10 even cols and row 11 are the saturating forms.
      dec_elem = sdd_pkg::SDD_ELEM_HALF;
      dec_saturate = (row == 2'h0 && col[2] && col != 3'h7) ||
                     (row == 2'h1 && col[2] && !col[1]) || row == 2'h3 ||
                     (row == 2'h2 && !col[0]);
      if ((row == 2'h0 || row == 2'h1) && col[1:0] == 2'h3) begin
        dec_elem = sdd_pkg::SDD_ELEM_BYTE;
      end
    end else if (cls == sdd_pkg::SDD_CLS_DOT_64) begin
      dec_elem = sdd_pkg::SDD_ELEM_DOUBLE;
    end else if (cls == sdd_pkg::SDD_CLS_EXTRACT_32) begin
      if (row == 2'h0 || row == 2'h1) begin
        dec_variable = col[0];
        dec_round = fld.op == sdd_pkg::OP_ROUNDING_EXTRACT ||
                    fld.op == sdd_pkg::OP_ROUNDING_EXTRACT_VARIABLE;
        dec_saturate = row == 2'h1 || col == 3'h6 || col == 3'h7;
      end else if (fld.op == sdd_pkg::OP_ACCUMULATOR_PAIR_SHIFT_VARIABLE) begin
        dec_variable = 1'b1;
      end
    end
  end

  // Operation kind flags.
  always_comb begin
    dec_load = cls == sdd_pkg::SDD_CLS_INDEXED_LOAD && op_assigned;
    dec_load_unsigned = dec_load && fld.op == sdd_pkg::OP_INDEXED_UNSIGNED_BYTE_LOAD;
    dec_double_mul = 1'b0;
    if (cls == sdd_pkg::SDD_CLS_DOT_64 || cls == sdd_pkg::SDD_CLS_DOT_32) begin
      dec_double_mul = DOT_64_ENABLE && (fld.op == sdd_pkg::OP_DOUBLE_MULTIPLY_ADD ||
        fld.op == sdd_pkg::OP_DOUBLE_MULTIPLY_SUBTRACT ||
        fld.op == sdd_pkg::OP_DOUBLE_UNSIGNED_MULTIPLY_ADD ||
        fld.op == sdd_pkg::OP_DOUBLE_UNSIGNED_MULTIPLY_SUBTRACT);
    end
    dec_ctrl_read = cls == sdd_pkg::SDD_CLS_EXTRACT_32 &&
                    fld.op == sdd_pkg::OP_CONTROL_REGISTER_READ;
    dec_ctrl_write = cls == sdd_pkg::SDD_CLS_EXTRACT_32 &&
                     fld.op == sdd_pkg::OP_CONTROL_REGISTER_WRITE;
    dec_acc_shift_in = cls == sdd_pkg::SDD_CLS_EXTRACT_32 &&
                       fld.op == sdd_pkg::OP_ACCUMULATOR_SHIFT_IN;
    dec_acc_pair_shift = cls == sdd_pkg::SDD_CLS_EXTRACT_32 &&
                         (fld.op == sdd_pkg::OP_ACCUMULATOR_PAIR_SHIFT ||
                          fld.op == sdd_pkg::OP_ACCUMULATOR_PAIR_SHIFT_VARIABLE);
  end

  // Register, accumulator and immediate routing.
  always_comb begin
    dec_src_a = fld.src_a;
    dec_src_b = fld.src_b;
    dec_dst = fld.dst;
    dec_acc = fld.acc;
    dec_imm5 = fld.src_a;
    dec_mask = 6'h00;
    dec_src_a_used = 1'b0;
    dec_src_b_used = 1'b0;
    dec_dst_used = 1'b0;
    dec_acc_read = 1'b0;
    dec_acc_write = 1'b0;
    if (dec_hit && !dec_reserved) begin
      case (cls)
        sdd_pkg::SDD_CLS_INDEXED_LOAD: begin
          dec_src_a_used = 1'b1;
          dec_src_b_used = 1'b1;
          dec_dst_used = 1'b1;
        end
        sdd_pkg::SDD_CLS_SHIFT_32, sdd_pkg::SDD_CLS_SHIFT_64: begin
          dec_src_a_used = col[1];
          dec_src_b_used = 1'b1;
          dec_dst_used = 1'b1;
        end
        sdd_pkg::SDD_CLS_DOT_32, sdd_pkg::SDD_CLS_DOT_64: begin
          dec_src_a_used = 1'b1;
          dec_src_b_used = 1'b1;
          dec_acc_read = 1'b1;
          dec_acc_write = 1'b1;
        end
        sdd_pkg::SDD_CLS_EXTRACT_32: begin
          if (dec_ctrl_read) begin
            dec_dst_used = 1'b1;
            dec_mask = fld.rd_mask;
          end else if (dec_ctrl_write) begin
            dec_src_a_used = 1'b1;
            dec_mask = fld.wr_mask;
          end else if (dec_acc_shift_in) begin
            dec_src_a_used = 1'b1;
            dec_acc_read = 1'b1;
            dec_acc_write = 1'b1;
          end else if (dec_acc_pair_shift) begin
            dec_src_a_used = dec_variable;
            dec_acc_read = 1'b1;
            dec_acc_write = 1'b1;
          end else begin
            dec_dst = fld.src_b;
            dec_dst_used = 1'b1;
            dec_src_a_used = dec_variable;
            dec_acc_read = 1'b1;
          end
        end
        default: begin
          dec_dst_used = 1'b0;
        end
      endcase
    end
  end

  // Execute-stage copy, held while the pipeline stalls.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ex_valid_ff <= 1'b0;
      ex_reserved_ff <= 1'b0;
      ex_class_ff <= sdd_pkg::SDD_CLS_NONE;
      ex_op_ff <= 5'h00;
      ex_acc_ff <= 2'h0;
      ex_dst_ff <= 5'h00;
    end else if (!hold) begin
      ex_valid_ff <= dec_hit;
      ex_reserved_ff <= dec_reserved;
      ex_class_ff <= dec_class;
      ex_op_ff <= dec_op;
      ex_acc_ff <= dec_acc;
      ex_dst_ff <= dec_dst;
    end
  end
endmodule // sdd_decoder
`default_nettype wire

// file: dv/sdd_decoder_properties.sv
// Concurrent checks of the sub-class decoder at its ports.
`timescale 1ns/1ps
`default_nettype none
module sdd_decoder_checker (
  // Clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Fetch side.
  input wire logic instr_valid,
  input wire logic [31:0] instr,
  input wire logic hold,
  // Decode results.
  input wire logic dec_hit,
  input wire logic dec_reserved,
  input wire sdd_pkg::sdd_class_t dec_class,
  input wire logic dec_round,
  input wire logic dec_double_mul,
  input wire logic [1:0] dec_acc,
  input wire logic [5:0] dec_mask,
  input wire sdd_pkg::sdd_class_t ex_class_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic maj;
  logic pad;
  logic [4:0] op;
  logic [5:0] fn;
  assign maj = instr_valid && (instr[31:26] == 6'h1F);
  assign pad = instr[15:13] != 3'h0;
  assign op = instr[10:6];
  assign fn = instr[5:0];
  sequence s_taken;
    !hold;
  endsequence
  property p_idle_no_hit;
    !instr_valid |-> !dec_hit && dec_class == sdd_pkg::SDD_CLS_NONE;
  endproperty
  a_idle_no_hit: assert property (p_idle_no_hit) else $error("Hit without valid word");
  property p_load_class;
    maj && fn == 6'h0A |-> dec_hit && dec_class == sdd_pkg::SDD_CLS_INDEXED_LOAD;
  endproperty
  a_load_class: assert property (p_load_class) else $error("Load class missed");
  property p_load_ops;
    maj && fn == 6'h0A |-> dec_reserved == !sdd_pkg::MAP_INDEXED_LOAD[op];
  endproperty
  a_load_ops: assert property (p_load_ops) else $error("Load op map wrong");
  property p_shift32;
    maj && fn == 6'h13 |->
      dec_class == sdd_pkg::SDD_CLS_SHIFT_32 && dec_reserved == !sdd_pkg::MAP_SHIFT_32[op];
  endproperty
  a_shift32: assert property (p_shift32) else $error("Shift 32 map wrong");
  property p_shift64;
    maj && fn == 6'h17 |->
      dec_class == sdd_pkg::SDD_CLS_SHIFT_64 && dec_reserved == !sdd_pkg::MAP_SHIFT_64[op];
  endproperty
  a_shift64: assert property (p_shift64) else $error("Shift 64 map wrong");
  property p_dot_acc;
    maj && fn == 6'h30 |-> dec_acc == instr[12:11] && (!pad || dec_reserved);
  endproperty
  a_dot_acc: assert property (p_dot_acc) else $error("Accumulator field wrong");
  property p_double_mul;
    maj && fn == 6'h30 && op inside {5'h02, 5'h0A, 5'h1D, 5'h1F} |-> dec_double_mul;
  endproperty
  a_double_mul: assert property (p_double_mul) else $error("Double multiply missed");
  property p_round_extract;
    maj && fn == 6'h38 && !pad && op[4:1] == 4'h2 |-> dec_round && !dec_reserved;
  endproperty
  a_round_extract: assert property (p_round_extract) else $error("Rounding extract");
  property p_wr_mask;
    maj && fn == 6'h38 && op == 5'h13 |-> dec_mask == instr[16:11];
  endproperty
  a_wr_mask: assert property (p_wr_mask) else $error("Write mask wrong");
  property p_ex_capture;
    s_taken |=> ex_class_ff == $past(dec_class);
  endproperty
  a_ex_capture: assert property (p_ex_capture) else $error("Stage copy missed");
  property p_ex_hold;
    hold |=> $stable(ex_class_ff);
  endproperty
  a_ex_hold: assert property (p_ex_hold) else $error("Stage copy moved on stall");
endmodule // sdd_decoder_checker
bind sdd_decoder sdd_decoder_checker i_sdd_decoder_checker (.clk(clk), .rst(rst),
  .instr_valid(instr_valid), .instr(instr), .hold(hold), .dec_hit(dec_hit),
  .dec_reserved(dec_reserved), .dec_class(dec_class), .dec_round(dec_round),
  .dec_double_mul(dec_double_mul), .dec_acc(dec_acc), .dec_mask(dec_mask),
  .ex_class_ff(ex_class_ff));
`default_nettype wire

// file: dv/sdd_fetch_model.sv
// Fetch stage model that presents one instruction word per cycle.
`timescale 1ns/1ps
`default_nettype none
module sdd_fetch_model (
  // Clock.
  input wire logic clk,
  // Toward the decoder.
  output logic instr_valid,
  output logic [31:0] instr,
  output logic hold
);
  initial begin
    instr_valid = 1'b0;
    instr = 32'h0;
    hold = 1'b0;
  end
  // An idle slot shows the inverse of the last word so that no stale word looks valid.
  task automatic issue(input logic v, input logic [31:0] w, input logic h);
    @(negedge clk);
    instr_valid = v;
    instr = v ? w : ~instr;
    hold = h;
  endtask
endmodule // sdd_fetch_model
`default_nettype wire

// file: dv/sdd_decoder_tb_top.sv
// Self-checking bench for the packed-SIMD sub-class decoder.
`timescale 1ns/1ps
`default_nettype none
module sdd_decoder_tb_top;
  typedef struct {
    logic h;
    logic [31:0] w;
    logic hit;
    logic res;
    sdd_pkg::sdd_class_t cls;
    logic [6:0] kind;
    logic [5:0] mask;
    logic [3:0] sh;
  } sdd_note_t;
  logic clk, rst, instr_valid, hold, dec_hit, dec_reserved, dec_variable, dec_round;
  logic dec_double_mul, dec_load, dec_load_unsigned, dec_ctrl_read, dec_ctrl_write;
  logic dec_acc_shift_in, dec_acc_pair_shift, dec_src_a_used, dec_src_b_used, dec_dst_used;
  logic dec_acc_read, dec_acc_write, ex_reserved_ff, exp_res;
  logic [31:0] instr;
  logic [4:0] dec_op, dec_imm5, dec_src_a, dec_src_b, dec_dst;
  sdd_pkg::sdd_elem_t dec_elem;
  logic [1:0] dec_acc;
  logic [5:0] dec_mask;
  sdd_pkg::sdd_class_t dec_class, ex_class_ff, exp_cls;
  sdd_pkg::sdd_shift_t dec_shift;
  int err_count, total_checks;
  sdd_note_t q[$];
  initial clk = 1'b0;
  always #20 clk = ~clk;
  sdd_fetch_model i_sdd_fetch_model (.clk(clk), .instr_valid(instr_valid), .instr(instr),
    .hold(hold));
  sdd_decoder i_sdd_decoder (.clk(clk), .rst(rst), .instr_valid(instr_valid), .instr(instr),
    .hold(hold), .dec_hit(dec_hit), .dec_reserved(dec_reserved), .dec_class(dec_class),
    .dec_op(dec_op), .dec_elem(dec_elem), .dec_shift(dec_shift), .dec_variable(dec_variable),
    .dec_round(dec_round), .dec_saturate(), .dec_double_mul(dec_double_mul),
    .dec_load(dec_load), .dec_load_unsigned(dec_load_unsigned), .dec_ctrl_read(dec_ctrl_read),
    .dec_ctrl_write(dec_ctrl_write), .dec_acc_shift_in(dec_acc_shift_in),
    .dec_acc_pair_shift(dec_acc_pair_shift), .dec_src_a(dec_src_a),
    .dec_src_a_used(dec_src_a_used), .dec_src_b(dec_src_b), .dec_src_b_used(dec_src_b_used),
    .dec_dst(dec_dst), .dec_dst_used(dec_dst_used),
    .dec_acc(dec_acc), .dec_acc_read(dec_acc_read), .dec_acc_write(dec_acc_write),
    .dec_imm5(dec_imm5), .dec_mask(dec_mask), .ex_valid_ff(), .ex_reserved_ff(ex_reserved_ff),
    .ex_class_ff(ex_class_ff), .ex_op_ff(), .ex_acc_ff(), .ex_dst_ff());

  task automatic check_val(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic test_done;
    $display("Checks %0d, errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Builds the expected decode of one presented word.
  function automatic sdd_note_t expect_of(logic v, logic [31:0] w, logic h);
    sdd_note_t n;
    logic [4:0] op;
    logic pad, ok, ext;
    op = w[10:6];
    pad = w[15:13] != 3'h0;
    n = '{h, w, 1'b0, 1'b0, sdd_pkg::SDD_CLS_NONE, 7'h00, 6'h00, 4'h0};
    if (v && w[31:26] == 6'h1F) begin
      n.hit = 1'b1;
      case (w[5:0])
        6'h0A: begin
          n.cls = sdd_pkg::SDD_CLS_INDEXED_LOAD;
          n.res = !sdd_pkg::MAP_INDEXED_LOAD[op];
        end
        6'h13, 6'h17: begin
          n.cls = w[2] ? sdd_pkg::SDD_CLS_SHIFT_64 : sdd_pkg::SDD_CLS_SHIFT_32;
          n.res = !(w[2] ? sdd_pkg::MAP_SHIFT_64[op] : sdd_pkg::MAP_SHIFT_32[op]);
        end
        6'h30: begin
          n.cls = (op == 5'h02) ? sdd_pkg::SDD_CLS_DOT_64 : sdd_pkg::SDD_CLS_DOT_32;
          n.res = pad || (op != 5'h02 && !sdd_pkg::MAP_DOT_32[op]);
        end
        6'h38: begin
          n.cls = sdd_pkg::SDD_CLS_EXTRACT_32;
          n.res = !sdd_pkg::MAP_EXTRACT_32[op] || (pad && op[4:1] != 4'h9);
        end
        default: n.hit = 1'b0;
      endcase
    end
    ok = n.hit && !n.res;
    // Extract kind flags follow the op code even when the word is reserved.
    ext = n.cls == sdd_pkg::SDD_CLS_EXTRACT_32;
    n.kind = {ok && n.cls == sdd_pkg::SDD_CLS_INDEXED_LOAD,
      ok && n.cls == sdd_pkg::SDD_CLS_INDEXED_LOAD && op == 5'h06,
      n.cls inside {sdd_pkg::SDD_CLS_DOT_32, sdd_pkg::SDD_CLS_DOT_64} &&
        op inside {5'h02, 5'h0A, 5'h1D, 5'h1F},
      ext && op == 5'h12, ext && op == 5'h13, ext && op == 5'h1F, ext && op[4:1] == 4'hD};
    if (ext && op == 5'h12) n.mask = w[21:16];
    if (ext && op == 5'h13) n.mask = w[16:11];
    if (ok && n.cls inside {sdd_pkg::SDD_CLS_SHIFT_32, sdd_pkg::SDD_CLS_SHIFT_64} &&
        op[4:3] == 2'h0) n.sh = {op[2] ? 2'h3 : (op[0] ? 2'h2 : 2'h1), op[1], op[2] & op[0]};
    return n;
  endfunction

  task automatic check_dec(input sdd_note_t n);
    check_val("dec_hit", n.hit, dec_hit);
    check_val("dec_class", n.cls, dec_class);
    check_val("dec_reserved", n.res, dec_reserved);
    check_val("kinds", n.kind, {dec_load, dec_load_unsigned, dec_double_mul, dec_ctrl_read,
      dec_ctrl_write, dec_acc_shift_in, dec_acc_pair_shift});
    check_val("dec_mask", n.mask, dec_mask);
    if (n.sh != 4'h0) check_val("shift", n.sh, {dec_shift, dec_variable, dec_round});
    if (n.kind[6]) check_val("load regs", 3'h7, {dec_src_a_used, dec_src_b_used, dec_dst_used});
    if (n.kind[1] && !n.res) check_val("shift in", 3'h7,
      {dec_src_a_used, dec_acc_read, dec_acc_write});
    if (n.kind[0] && !n.res) check_val("pair shift", {2'h1, n.w[6]},
      {dec_src_b_used, dec_acc_write, dec_src_a_used});
    if (n.kind[6]) check_val("dec_elem", n.w[9] ? 2'h3 : (n.w[7] ? 2'h0 : (n.w[8] ? 2'h1 : 2'h2)),
      dec_elem);
    check_val("dec_dst", (!n.res && n.cls == sdd_pkg::SDD_CLS_EXTRACT_32 && !n.w[10]) ?
      n.w[20:16] : n.w[15:11], dec_dst);
    if (n.hit) begin
      check_val("dec_op", n.w[10:6], dec_op);
      check_val("dec_acc", n.w[12:11], dec_acc);
      check_val("dec_imm5", n.w[25:21], dec_imm5);
      check_val("dec_src", n.w[25:16], {dec_src_a, dec_src_b});
    end
    if (n.res || !n.hit) check_val("used", 5'h00, {dec_src_a_used, dec_src_b_used,
      dec_dst_used, dec_acc_read, dec_acc_write});
  endtask

  always @(posedge clk) begin : monitor
    sdd_note_t n;
    if (q.size() > 0) begin
      n = q.pop_front();
      check_dec(n);
      if (!n.h) begin
        exp_cls = n.cls;
        exp_res = n.res;
      end
      #1;
      check_val("ex_class_ff", exp_cls, ex_class_ff);
      check_val("ex_reserved_ff", exp_res, ex_reserved_ff);
    end
  end

  function automatic logic [31:0] mk(logic [5:0] fn, logic [4:0] op, logic [2:0] pad);
    return {6'h1F, 10'($urandom), pad, 2'($urandom), op, fn};
  endfunction

  task automatic send(input logic v, input logic [31:0] w);
    logic h;
    h = ($urandom % 5) == 0;
    i_sdd_fetch_model.issue(v, w, h);
    q.push_back(expect_of(v, instr, h));
  endtask

  task automatic do_reset;
    // An idle word with the stall low keeps a stale word out of the stage copy after release.
    i_sdd_fetch_model.issue(1'b0, 32'h0, 1'b0);
    rst = 1'b1;
    repeat (16) @(posedge clk);
    #1;
    check_val("ex_class_ff", sdd_pkg::SDD_CLS_NONE, ex_class_ff);
    exp_cls = sdd_pkg::SDD_CLS_NONE;
    exp_res = 1'b0;
    @(negedge clk);
    rst = 1'b0;
  endtask

  initial begin : main
    logic [5:0] fns [5];
    logic [31:0] seed;
    fns = '{6'h0A, 6'h13, 6'h17, 6'h30, 6'h38};
    err_count = 0;
    total_checks = 0;
    rst = 1'b1;
    seed = $urandom(32'h32b1);
    do_reset();
    foreach (fns[i]) begin
      for (int k = 0; k < 32; k++) begin
        send(1'b1, mk(fns[i], 5'(k), 3'h0));
      end
    end
    send(1'b1, mk(6'h30, 5'h00, 3'h5));
    send(1'b1, mk(6'h38, 5'h04, 3'h1));
    send(1'b1, mk(6'h38, 5'h13, 3'h7));
    send(1'b1, mk(6'h38, 5'h12, 3'h2));
    send(1'b1, mk(6'h0A, 5'h00, 3'h0) ^ 32'h0400_0000);
    send(1'b1, mk(6'h10, 5'h00, 3'h0));
    send(1'b0, 32'h0);
    repeat (40) send(1'b1, mk(fns[$urandom % 5], 5'($urandom),
      ($urandom % 4 == 0) ? 3'($urandom) : 3'h0));
    do_reset();
    repeat (4) send(1'b1, mk(6'h30, 5'($urandom), 3'h0));
    @(posedge clk);
    @(posedge clk);
    test_done();
  end

  initial begin : watchdog
    #(40 * 20000);
    err_count++;
    test_done();
  end
endmodule // sdd_decoder_tb_top
`default_nettype wire
